// file: src/lbpd_loop_ctrl.sv
`timescale 1ns/1ps
module lbpd_loop_ctrl (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire lbpd_pkg::lbpd_loop_cfg_s cfg,
  output logic [9:0]                   cp_current_ua,
  output logic [10:0]                  series_res_ohm,
  output logic [7:0]                   par_cap_pf,
  output logic [10:0]                  post_res_ohm,
  output logic [4:0]                   lock_ppm,
  output logic                         lock_auto,
  output logic                         vco_a_active,
  output logic [4:0]                   lock_code,
  output logic                         loop_run
);
  logic [9:0]  cp_nxt;
  logic [10:0] rs_nxt;
  logic [7:0]  cap_nxt;
  logic [10:0] post_nxt;
  logic [4:0]  ppm_nxt;
  logic [4:0]  code_nxt;

  function automatic logic [10:0] rs_ohm(input logic [1:0] s);
    case (s)
      2'h0:    rs_ohm = 11'h14a;
      2'h1:    rs_ohm = 11'h280;
      2'h2:    rs_ohm = 11'h4b0;
      default: rs_ohm = 11'h6fe;
    endcase
  endfunction

  function automatic logic [7:0] cap_pf(input logic [1:0] s);
    case (s)
      2'h0:    cap_pf = 8'h28;
      2'h1:    cap_pf = 8'h50;
      2'h2:    cap_pf = 8'h8c;
      default: cap_pf = 8'hc8;
    endcase
  endfunction

  // Decode of analog settings
  always_comb begin
    cp_nxt   = 10'((11'(cfg.cp_sel) + 11'h001) * 11'(lbpd_pkg::CP_STEP_UA));
    rs_nxt   = rs_ohm(cfg.rs_sel);
    cap_nxt  = cap_pf(cfg.cap_sel);
    post_nxt = cfg.pole_sel ? lbpd_pkg::RPOST_HI_OHM : lbpd_pkg::RPOST_LO_OHM;
    ppm_nxt  = cfg.lock_acc ? lbpd_pkg::LOCK_PPM_HI : lbpd_pkg::LOCK_PPM_LO;
    code_nxt = cfg.vco_sel ? cfg.code_a : cfg.code_b;
  end

  // Output registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cp_current_ua  <= 10'h000;
      series_res_ohm <= 11'h000;
      par_cap_pf     <= 8'h00;
      post_res_ohm   <= 11'h000;
      lock_ppm       <= 5'h00;
      lock_auto      <= 1'b1;
      vco_a_active   <= 1'b1;
      lock_code      <= 5'h00;
      loop_run       <= 1'b0;
    end else begin
      cp_current_ua  <= cp_nxt;
      series_res_ohm <= rs_nxt;
      par_cap_pf     <= cap_nxt;
      post_res_ohm   <= post_nxt;
      lock_ppm       <= ppm_nxt;
      lock_auto      <= ~cfg.lock_manual;
      vco_a_active   <= cfg.vco_sel;
      lock_code      <= code_nxt;
      loop_run       <= ~cfg.loop_disable;
    end
  end
endmodule

// file: src/lbpd_pkg.sv
package lbpd_pkg;

  // ----------------------------------------
  // Bus and counts
  // ----------------------------------------
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned N_REG   = 9;
  localparam int unsigned N_INREF = 4;
  localparam int unsigned N_OUT   = 8;
  localparam int unsigned N_DLOOP = 2;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] OFS_FILTER = 16'h00b0;
  localparam logic [15:0] OFS_MODE   = 16'h00b1;
  localparam logic [15:0] OFS_CODE_A = 16'h00b2;
  localparam logic [15:0] OFS_CODE_B = 16'h00b3;
  localparam logic [15:0] OFS_SPARE  = 16'h00b4;
  localparam logic [15:0] OFS_INREF  = 16'h00b5;
  localparam logic [15:0] OFS_ALOOP  = 16'h00b6;
  localparam logic [15:0] OFS_OUT    = 16'h00b7;
  localparam logic [15:0] OFS_DLCAL  = 16'h00b8;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned CPSET_LSB  = 5;
  localparam int unsigned RS_LSB     = 3;
  localparam int unsigned CP_LSB     = 1;
  localparam int unsigned WPOST_BIT  = 0;
  localparam int unsigned SYN_BIT    = 3;
  localparam int unsigned DLCNT_BIT  = 1;
  localparam int unsigned DBITM_BIT  = 0;
  localparam int unsigned VCOMAN_BIT = 5;
  localparam int unsigned CODE_LSB   = 0;
  localparam int unsigned DBL_BIT    = 0;
  localparam int unsigned ALDIS_BIT  = 4;
  localparam int unsigned DLDIS_LSB  = 2;
  localparam int unsigned CALRST_LSB = 0;

  // ----------------------------------------
  // Writable bit masks per register
  // ----------------------------------------
  localparam logic [7:0] MASK_FILTER = 8'hff;
  localparam logic [7:0] MASK_MODE   = 8'h0b;
  localparam logic [7:0] MASK_CODE_A = 8'h3f;
  localparam logic [7:0] MASK_CODE_B = 8'h1f;
  localparam logic [7:0] MASK_SPARE  = 8'h01;
  localparam logic [7:0] MASK_INREF  = 8'h0f;
  localparam logic [7:0] MASK_ALOOP  = 8'h10;
  localparam logic [7:0] MASK_OUT    = 8'hff;
  localparam logic [7:0] MASK_DLCAL  = 8'h0f;

  // ----------------------------------------
  // Reset values (whole bytes)
  // ----------------------------------------
  localparam logic [7:0] RST_FILTER = 8'h8b;
  localparam logic [7:0] RST_MODE   = 8'h02;
  localparam logic [7:0] RST_CODE_A = 8'h2b;
  localparam logic [7:0] RST_CODE_B = 8'h00;
  localparam logic [7:0] RST_ZERO   = 8'h00;

  // ----------------------------------------
  // Analog decode constants
  // ----------------------------------------
  localparam logic [9:0]  CP_STEP_UA   = 10'h06e;
  localparam logic [10:0] RPOST_LO_OHM = 11'h1f1;
  localparam logic [10:0] RPOST_HI_OHM = 11'h62c;
  localparam logic [7:0]  CPOST_PF     = 8'h28;
  localparam logic [4:0]  LOCK_PPM_HI  = 5'h10;
  localparam logic [4:0]  LOCK_PPM_LO  = 5'h01;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] cp_sel;
    logic [1:0] rs_sel;
    logic [1:0] cap_sel;
    logic       pole_sel;
    logic       lock_acc;
    logic       lock_manual;
    logic       vco_sel;
    logic [4:0] code_a;
    logic [4:0] code_b;
    logic       synth_only;
    logic       loop_disable;
    logic       cal_reset;
  } lbpd_loop_cfg_s;

  typedef struct packed {
    logic         doubler_bypass;
    logic [3:0]   inref_disable;
    logic [7:0]   out_disable;
    logic [1:0]   dloop_disable;
    logic [1:0]   cal_reset;
  } lbpd_power_cfg_s;

endpackage

// file: src/lbpd_power_ctrl.sv
`timescale 1ns/1ps
module lbpd_power_ctrl (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire lbpd_pkg::lbpd_power_cfg_s cfg,
  output logic [3:0]                    inref_en,
  output logic [7:0]                    out_oe,
  output logic [1:0]                    dloop_en,
  output logic [1:0]                    cal_run,
  output logic                          xtal_doubled
);
  lbpd_pkg::lbpd_power_cfg_s cfg_nxt;

  // Pass settings into the register stage
  always_comb begin
    cfg_nxt = cfg;
  end

  // Enables are the inverse of the disable bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inref_en     <= 4'h0;
      out_oe       <= 8'h00;
      dloop_en     <= 2'h0;
      cal_run      <= 2'h0;
      xtal_doubled <= 1'b0;
    end else begin
      inref_en     <= ~cfg_nxt.inref_disable;
      out_oe       <= ~cfg_nxt.out_disable;
      dloop_en     <= ~cfg_nxt.dloop_disable;
      cal_run      <= ~cfg_nxt.cal_reset;
      xtal_doubled <= ~cfg_nxt.doubler_bypass;
    end
  end
endmodule

// file: src/lbpd_regs.sv
// Overview of operation
// - Charge pump current code resets to 100b; steps of 110 uA from 110 uA.
// - Series resistor code resets to 01b; 330, 640, 1200 or 1790 ohms.
// - Parallel capacitor code resets to 01b; 40, 80, 140 or 200 pF.
// - Second pole bit resets to 1; 1 picks higher post resistance.
// - Lock accuracy bit resets to 1 (16 ppm); software clears it above 95nF.
// - Lock override bit: 0 automatic lock (default), 1 manual lock codes.
// - Manual VCO select: 1 first VCO (default), 0 second VCO.
// - Two five-bit manual lock codes, defaults 01011b and 00000b.
// - Synth-only bit resets to 0; 1 uses crystal reference alone.
// - Reserved bits are written as zero; reads of them are undefined.
// - Doubler bypass resets to 0 (doubled crystal); 1 uses plain crystal.
// - Four input reference disable bits in 00B5 bits 3..0, default 0.
// - Analog loop disable bit in 00B6 disables second loop when 1.
// - Eight output disable bits in 00B7 turn off logic and driver.
// - Two digital loop disable bits in 00B8, default 0 enabled.
// - Two calibration reset bits hold calibration off while set.
// - Second loop fields sit in 00B0..00B3, 00B6 bit 4 and 00B8 bit 1 at their fixed bit positions.
`timescale 1ns/1ps
module lbpd_regs #(
  parameter logic [1:0] FREERUN_STATE = 2'h3
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] cfg_addr,
  input  wire logic [7:0]  cfg_wdata,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  output logic [7:0]       cfg_rdata,
  output logic             cfg_rd_valid,
  input  wire logic [1:0]  digital_loop_state_field,
  output logic             synth_state_mismatch,
  output logic             synth_only_mode,
  output logic             lock_manual_override,
  output logic [4:0]       manual_lock_code_vco_a,
  output logic [4:0]       manual_lock_code_vco_b,
  output logic [9:0]       cp_current_ua,
  output logic [10:0]      series_res_ohm,
  output logic [7:0]       par_cap_pf,
  output logic [10:0]      post_res_ohm,
  output logic [4:0]       lock_ppm,
  output logic             lock_auto,
  output logic             vco_a_active,
  output logic [4:0]       lock_code,
  output logic             loop_b_run,
  output logic [3:0]       inref_en,
  output logic [7:0]       out_oe,
  output logic [1:0]       dloop_en,
  output logic [1:0]       cal_run,
  output logic             xtal_doubled
);

  // ----------------------------------------
  // Address helpers
  // ----------------------------------------

  // True when the address falls in the bank
  function automatic logic addr_hit(
    input logic [15:0] a
  );
    addr_hit = (a >= lbpd_pkg::OFS_FILTER) &&
               (a <= lbpd_pkg::OFS_DLCAL);
  endfunction

  // Index of a byte register within the bank
  function automatic logic [3:0] addr_idx(
    input logic [15:0] a
  );
    logic [15:0] d;
    d = a - lbpd_pkg::OFS_FILTER;
    addr_idx = d[3:0];
  endfunction

  // Writable bits of each register
  function automatic logic [7:0] wr_mask(
    input logic [3:0] i
  );
    case (i)
      4'h0:    wr_mask = lbpd_pkg::MASK_FILTER;
      4'h1:    wr_mask = lbpd_pkg::MASK_MODE;
      4'h2:    wr_mask = lbpd_pkg::MASK_CODE_A;
      4'h3:    wr_mask = lbpd_pkg::MASK_CODE_B;
      4'h4:    wr_mask = lbpd_pkg::MASK_SPARE;
      4'h5:    wr_mask = lbpd_pkg::MASK_INREF;
      4'h6:    wr_mask = lbpd_pkg::MASK_ALOOP;
      4'h7:    wr_mask = lbpd_pkg::MASK_OUT;
      4'h8:    wr_mask = lbpd_pkg::MASK_DLCAL;
      default: wr_mask = 8'h00;
    endcase
  endfunction

  // Reset value of each register
  function automatic logic [7:0] rst_val(
    input logic [3:0] i
  );
    case (i)
      4'h0:    rst_val = lbpd_pkg::RST_FILTER;
      4'h1:    rst_val = lbpd_pkg::RST_MODE;
      4'h2:    rst_val = lbpd_pkg::RST_CODE_A;
      4'h3:    rst_val = lbpd_pkg::RST_CODE_B;
      default: rst_val = lbpd_pkg::RST_ZERO;
    endcase
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0]  reg_r   [lbpd_pkg::N_REG];
  logic [7:0]  reg_nxt [lbpd_pkg::N_REG];
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        rvld_r;
  logic        rvld_nxt;
  logic        mism_r;
  logic        mism_nxt;
  logic        hit;
  logic [3:0]  idx;

  // Decode of the current access
  assign hit = addr_hit(cfg_addr);
  assign idx = addr_idx(cfg_addr);

  // Next values of the register bank
  always_comb begin
    for (int i = 0; i < lbpd_pkg::N_REG; i++) begin
      reg_nxt[i] = reg_r[i];
    end
    if (cfg_wr && hit) begin
      // Reserved bits never store anything
      reg_nxt[idx] = cfg_wdata & wr_mask(idx);
    end
  end

  // Bank registers with per-field defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_r[0] <= lbpd_pkg::RST_FILTER;
      reg_r[1] <= lbpd_pkg::RST_MODE;
      reg_r[2] <= lbpd_pkg::RST_CODE_A;
      reg_r[3] <= lbpd_pkg::RST_CODE_B;
      reg_r[4] <= lbpd_pkg::RST_ZERO;
      reg_r[5] <= lbpd_pkg::RST_ZERO;
      reg_r[6] <= lbpd_pkg::RST_ZERO;
      reg_r[7] <= lbpd_pkg::RST_ZERO;
      reg_r[8] <= lbpd_pkg::RST_ZERO;
    end else begin
      for (int i = 0; i < lbpd_pkg::N_REG; i++) begin
        reg_r[i] <= reg_nxt[i];
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------

  // Read data one cycle after the strobe
  always_comb begin
    rdata_nxt = rdata_r;
    rvld_nxt  = cfg_rd;
    if (cfg_rd) begin
      if (hit) begin
        rdata_nxt = reg_r[idx];
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  // Read data registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
      rvld_r  <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvld_r  <= rvld_nxt;
    end
  end

  assign cfg_rdata    = rdata_r;
  assign cfg_rd_valid = rvld_r;

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  lbpd_pkg::lbpd_loop_cfg_s  loop_cfg;
  lbpd_pkg::lbpd_power_cfg_s pwr_cfg;

  // Second loop fields
  always_comb begin
    loop_cfg.cp_sel       = reg_r[0][lbpd_pkg::CPSET_LSB +: 3];
    loop_cfg.rs_sel       = reg_r[0][lbpd_pkg::RS_LSB +: 2];
    loop_cfg.cap_sel      = reg_r[0][lbpd_pkg::CP_LSB +: 2];
    loop_cfg.pole_sel     = reg_r[0][lbpd_pkg::WPOST_BIT];
    loop_cfg.lock_acc     = reg_r[1][lbpd_pkg::DLCNT_BIT];
    loop_cfg.lock_manual  = reg_r[1][lbpd_pkg::DBITM_BIT];
    loop_cfg.synth_only   = reg_r[1][lbpd_pkg::SYN_BIT];
    loop_cfg.vco_sel      = reg_r[2][lbpd_pkg::VCOMAN_BIT];
    loop_cfg.code_a       = reg_r[2][lbpd_pkg::CODE_LSB +: 5];
    loop_cfg.code_b       = reg_r[3][lbpd_pkg::CODE_LSB +: 5];
    loop_cfg.loop_disable = reg_r[6][lbpd_pkg::ALDIS_BIT];
    loop_cfg.cal_reset    = reg_r[8][lbpd_pkg::CALRST_LSB + 1];
  end

  // Power-down fields
  always_comb begin
    pwr_cfg.doubler_bypass = reg_r[4][lbpd_pkg::DBL_BIT];
    pwr_cfg.inref_disable  = reg_r[5][3:0];
    pwr_cfg.out_disable    = reg_r[7];
    pwr_cfg.dloop_disable  = reg_r[8][lbpd_pkg::DLDIS_LSB +: 2];
    pwr_cfg.cal_reset      = reg_r[8][lbpd_pkg::CALRST_LSB +: 2];
  end

  // Raw mode fields for the loop logic
  assign synth_only_mode        = loop_cfg.synth_only;
  assign lock_manual_override   = loop_cfg.lock_manual;
  assign manual_lock_code_vco_a = loop_cfg.code_a;
  assign manual_lock_code_vco_b = loop_cfg.code_b;

  // ----------------------------------------
  // Synth-only consistency flag
  // ----------------------------------------

  // Flags synth-only mode without forced free-run
  always_comb begin
    mism_nxt = loop_cfg.synth_only &&
               (digital_loop_state_field != FREERUN_STATE);
  end

  // Consistency flag register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mism_r <= 1'b0;
    end else begin
      mism_r <= mism_nxt;
    end
  end

  assign synth_state_mismatch = mism_r;

  // ----------------------------------------
  // Second loop control
  // ----------------------------------------
  lbpd_loop_ctrl u_loop (
    .clk            (clk),
    .rst            (rst),
    .cfg            (loop_cfg),
    .cp_current_ua  (cp_current_ua),
    .series_res_ohm (series_res_ohm),
    .par_cap_pf     (par_cap_pf),
    .post_res_ohm   (post_res_ohm),
    .lock_ppm       (lock_ppm),
    .lock_auto      (lock_auto),
    .vco_a_active   (vco_a_active),
    .lock_code      (lock_code),
    .loop_run       (loop_b_run)
  );

  // ----------------------------------------
  // Power-down control
  // ----------------------------------------
  lbpd_power_ctrl u_power (
    .clk          (clk),
    .rst          (rst),
    .cfg          (pwr_cfg),
    .inref_en     (inref_en),
    .out_oe       (out_oe),
    .dloop_en     (dloop_en),
    .cal_run      (cal_run),
    .xtal_doubled (xtal_doubled)
  );

endmodule

// file: verification/lbpd_regs_asserts.sv
`timescale 1ns/1ps
module lbpd_regs_asserts #(
  parameter logic [1:0] FREERUN_STATE = 2'h3
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] cfg_addr,
  input wire logic [7:0]  cfg_wdata,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic        cfg_rd_valid,
  input wire logic [1:0]  digital_loop_state_field,
  input wire logic        synth_state_mismatch,
  input wire logic        synth_only_mode,
  input wire logic        lock_manual_override,
  input wire logic [4:0]  manual_lock_code_vco_a,
  input wire logic [4:0]  manual_lock_code_vco_b,
  input wire logic [9:0]  cp_current_ua,
  input wire logic [10:0] series_res_ohm,
  input wire logic [7:0]  par_cap_pf,
  input wire logic [10:0] post_res_ohm,
  input wire logic [4:0]  lock_ppm,
  input wire logic        lock_auto,
  input wire logic        vco_a_active,
  input wire logic [4:0]  lock_code,
  input wire logic        loop_b_run,
  input wire logic [3:0]  inref_en,
  input wire logic [7:0]  out_oe,
  input wire logic [1:0]  dloop_en,
  input wire logic [1:0]  cal_run,
  input wire logic        xtal_doubled
);
  // ----
  // Helpers
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [7:0] wd1;
  logic [7:0] wd2;

  // Write data delayed to the cycle the decoders show it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd1 <= 8'h00;
      wd2 <= 8'h00;
    end else begin
      wd1 <= cfg_wdata;
      wd2 <= wd1;
    end
  end

  // One write to an address, not rewritten next cycle
  sequence s_wr(logic [15:0] a);
    (cfg_wr && cfg_addr == a) ##1 !(cfg_wr && cfg_addr == a);
  endsequence

  sequence s_rd_once;
    cfg_rd ##1 !cfg_rd;
  endsequence

  // ----
  // Checks
  // ----
  rd_pulse_a: assert property (s_rd_once |-> cfg_rd_valid ##1 !cfg_rd_valid)
    else $error("read valid pulse wrong");
  cp_code_a: assert property (s_wr(16'h00b0) |=> cp_current_ua == ({7'h00, wd2[7:5]} + 10'h001) * 10'h06e)
    else $error("charge pump current wrong");
  res_code_a: assert property (s_wr(16'h00b0) |=> series_res_ohm == (wd2[4:3] == 2'h0 ? 11'h14a :
    wd2[4:3] == 2'h1 ? 11'h280 : wd2[4:3] == 2'h2 ? 11'h4b0 : 11'h6fe))
    else $error("series resistor wrong");
  cap_pole_a: assert property (s_wr(16'h00b0) |=> par_cap_pf == (wd2[2:1] == 2'h0 ? 8'h28 : wd2[2:1] == 2'h1 ?
    8'h50 : wd2[2:1] == 2'h2 ? 8'h8c : 8'hc8) && post_res_ohm == (wd2[0] ? 11'h62c : 11'h1f1))
    else $error("capacitor or pole wrong");
  mode_dec_a: assert property (s_wr(16'h00b1) |=> lock_ppm == (wd2[1] ? 5'h10 : 5'h01) && lock_auto == !wd2[0]
    && lock_manual_override == wd2[0] && synth_only_mode == wd2[3])
    else $error("mode decode wrong");
  vco_pick_a: assert property (s_wr(16'h00b2) |=> vco_a_active == wd2[5] && manual_lock_code_vco_a == wd2[4:0]
    && lock_code == (wd2[5] ? wd2[4:0] : manual_lock_code_vco_b))
    else $error("manual vco code wrong");
  synth_check_a: assert property (synth_state_mismatch ==
    $past(synth_only_mode && digital_loop_state_field != FREERUN_STATE))
    else $error("synth state flag wrong");
  xtal_doubler_a: assert property (s_wr(16'h00b4) |=> xtal_doubled == !wd2[0])
    else $error("doubler bypass wrong");
  inref_dis_a: assert property (s_wr(16'h00b5) |=> inref_en == ~wd2[3:0])
    else $error("input ref enable wrong");
  aloop_dis_a: assert property (s_wr(16'h00b6) |=> loop_b_run == !wd2[4])
    else $error("analog loop run wrong");
  out_dis_a: assert property (s_wr(16'h00b7) |=> out_oe == ~wd2)
    else $error("output enable wrong");
  dloop_cal_a: assert property (s_wr(16'h00b8) |=> dloop_en == ~wd2[3:2] && cal_run == ~wd2[1:0])
    else $error("digital loop or cal wrong");
endmodule

bind lbpd_regs lbpd_regs_asserts #(.FREERUN_STATE(FREERUN_STATE)) u_lbpd_chk (
  .clk(clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
  .cfg_rd_valid(cfg_rd_valid), .digital_loop_state_field(digital_loop_state_field),
  .synth_state_mismatch(synth_state_mismatch), .synth_only_mode(synth_only_mode),
  .lock_manual_override(lock_manual_override), .manual_lock_code_vco_a(manual_lock_code_vco_a),
  .manual_lock_code_vco_b(manual_lock_code_vco_b), .cp_current_ua(cp_current_ua), .series_res_ohm(series_res_ohm),
  .par_cap_pf(par_cap_pf), .post_res_ohm(post_res_ohm), .lock_ppm(lock_ppm), .lock_auto(lock_auto),
  .vco_a_active(vco_a_active), .lock_code(lock_code), .loop_b_run(loop_b_run), .inref_en(inref_en),
  .out_oe(out_oe), .dloop_en(dloop_en), .cal_run(cal_run), .xtal_doubled(xtal_doubled)
);

// file: verification/lbpd_regs_tb.sv
`timescale 1ns/1ps
module lbpd_regs_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] cfg_addr = 16'h0000;
  logic [7:0]  cfg_wdata = 8'h00;
  logic        cfg_wr = 1'b0;
  logic        cfg_rd = 1'b0;
  logic [1:0]  st_fld = 2'h0;
  logic [7:0]  cfg_rdata, par_cap_pf, out_oe, rv;
  logic        rd_vld, mism, synth, ovr, auto, vco_a, run, xtal;
  logic [4:0]  code_a, code_b, ppm, lcode;
  logic [9:0]  cp;
  logic [10:0] rs, post;
  logic [3:0]  inref_en;
  logic [1:0]  dloop_en, cal_run;
  int          err_count = 0;
  int          checked = 0;
  logic [7:0]  msk [9] = '{8'hff, 8'h0b, 8'h3f, 8'h1f, 8'h01, 8'h0f, 8'h10, 8'hff, 8'h0f};
  logic [7:0]  dft [9] = '{8'h8b, 8'h02, 8'h2b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [15:0] rs_t [4] = '{16'h014a, 16'h0280, 16'h04b0, 16'h06fe};
  logic [15:0] cap_t [4] = '{16'h0028, 16'h0050, 16'h008c, 16'h00c8};

  // Clock at 50 MHz
  always #10 clk = ~clk;

  lbpd_regs dut (
    .clk(clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_rdata(cfg_rdata), .cfg_rd_valid(rd_vld), .digital_loop_state_field(st_fld),
    .synth_state_mismatch(mism), .synth_only_mode(synth), .lock_manual_override(ovr),
    .manual_lock_code_vco_a(code_a), .manual_lock_code_vco_b(code_b), .cp_current_ua(cp),
    .series_res_ohm(rs), .par_cap_pf(par_cap_pf), .post_res_ohm(post), .lock_ppm(ppm), .lock_auto(auto),
    .vco_a_active(vco_a), .lock_code(lcode), .loop_b_run(run), .inref_en(inref_en), .out_oe(out_oe),
    .dloop_en(dloop_en), .cal_run(cal_run), .xtal_doubled(xtal)
  );

  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask

  // Read with valid pulse one cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    chk("rd_valid", 16'(rd_vld), 16'h0001);
    rv = cfg_rdata;
  endtask

  task automatic chk_defaults;
    for (int i = 0; i < 9; i++) begin
      rd(16'h00b0 + 16'(i));
      chk("dft_reg", 16'(rv & msk[i]), 16'(dft[i]));
    end
    chk("cp", 16'(cp), 16'h0226);
    chk("rs", 16'(rs), 16'h0280);
    chk("cap", 16'(par_cap_pf), 16'h0050);
    chk("post", 16'(post), 16'h062c);
    chk("ppm", 16'(ppm), 16'h0010);
    chk("auto", 16'({auto, ovr}), 16'h0002);
    chk("vco_a", 16'(vco_a), 16'h0001);
    chk("codes", 16'({code_a, code_b, lcode}), 16'h2c0b);
    chk("synth", 16'(synth), 16'h0000);
    chk("xtal", 16'(xtal), 16'h0001);
    chk("pwr", {inref_en, out_oe, dloop_en, cal_run}, 16'hffff);
    chk("run", 16'(run), 16'h0001);
  endtask

  // ----
  // Main sequence, reserved bits always written as zero
  // ----
  initial begin
    logic [7:0] d;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk_defaults();
    for (int i = 0; i < 8; i++) begin
      d = {3'(i), 2'(i), 2'(i + 1), 1'(i)};
      wr(16'h00b0, d);
      rd(16'h00b0);
      chk("filt_rb", 16'(rv), 16'(d));
      chk("cp", 16'(cp), 16'((i + 1) * 16'h006e));
      chk("rs", 16'(rs), rs_t[i % 4]);
      chk("cap", 16'(par_cap_pf), cap_t[(i + 1) % 4]);
      chk("post", 16'(post), i[0] ? 16'h062c : 16'h01f1);
    end
    for (int i = 0; i < 4; i++) begin
      d = {4'h0, 1'(i >> 1), 1'b0, 1'(i), 1'(i >> 1)};
      wr(16'h00b1, d);
      rd(16'h00b1);
      chk("mode_rb", 16'(rv & 8'h0b), 16'(d));
      chk("ppm", 16'(ppm), i[0] ? 16'h0010 : 16'h0001);
      chk("auto", 16'({auto, ovr}), i[1] ? 16'h0001 : 16'h0002);
      chk("synth", 16'({synth, mism}), i[1] ? 16'h0003 : 16'h0000);
    end
    @(posedge clk);
    st_fld <= 2'h3;
    repeat (2) @(posedge clk);
    #1;
    chk("mism", 16'(mism), 16'h0000);
    wr(16'h00b1, 8'h02);
    wr(16'h00b3, 8'h0a);
    for (int j = 0; j < 2; j++) begin
      wr(16'h00b2, {2'h0, 1'(j), 5'h15});
      rd(16'h00b2);
      chk("vco_a", 16'(vco_a), 16'(j));
      chk("codes", 16'({code_a, code_b, lcode}), j ? 16'h5555 : 16'h554a);
    end
    for (int k = 0; k < 2; k++) begin
      d = k ? 8'h5a : 8'ha5;
      wr(16'h00b4, 8'(1 - k));
      wr(16'h00b5, d & 8'h0f);
      wr(16'h00b6, k ? 8'h00 : 8'h10);
      wr(16'h00b7, d);
      wr(16'h00b8, d & 8'h0f);
      rd(16'h00b7);
      chk("out_rb", 16'(rv), 16'(d));
      chk("pwr", {inref_en, out_oe, dloop_en, cal_run}, {~d[3:0], ~d, ~d[3:2], ~d[1:0]});
      chk("run", 16'({xtal, run}), 16'(k * 3));
    end
    // Write and read in one cycle return the old byte
    @(posedge clk);
    cfg_addr <= 16'h00b7;
    cfg_wdata <= 8'h33;
    cfg_wr <= 1'b1;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    #1;
    chk("old", 16'(cfg_rdata), 16'h005a);
    wr(16'h00b9, 8'hff);
    rd(16'h00b9);
    chk("unmapped", 16'(rv), 16'h0000);
    chk("same_wr", 16'(out_oe), 16'h00cc);
    // Reset in mid-run restores every default
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk_defaults();
    report_and_stop();
  end

  // Watchdog far beyond the expected run
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule
